// ==== pkg/cte_pkg.sv ====
`default_nettype none
package cte_pkg;
  localparam int APB_AW = 8;
  localparam int APB_DW = 32;

  // Register byte offsets
  localparam logic [APB_AW-1:0] ADDR_CTRL     = 8'h00;
  localparam logic [APB_AW-1:0] ADDR_CMD      = 8'h04;
  localparam logic [APB_AW-1:0] ADDR_EXPOSURE = 8'h08;
  localparam logic [APB_AW-1:0] ADDR_INTERVAL = 8'h0C;
  localparam logic [APB_AW-1:0] ADDR_READOUT  = 8'h10;
  localparam logic [APB_AW-1:0] ADDR_FRAMES   = 8'h14;
  localparam logic [APB_AW-1:0] ADDR_STATUS   = 8'h18;

  // Field positions
  localparam int CTRL_SEL_LSB  = 0;
  localparam int CTRL_POL_BIT  = 2;
  localparam int CMD_START_BIT = 0;
  localparam int CMD_HALT_BIT  = 1;
  localparam int STAT_EXP_BIT  = 8;
  localparam int STAT_RDO_BIT  = 9;
  localparam int STAT_CNT_LSB  = 16;

  // Values after reset (times in clk cycles)
  localparam logic [2:0]  CTRL_RST     = 3'h0;
  localparam logic [31:0] EXPOSURE_RST = 32'h0000_0064;
  localparam logic [31:0] INTERVAL_RST = 32'h0000_07D0;
  localparam logic [31:0] READOUT_RST  = 32'h0000_03E8;
  localparam logic [15:0] FRAMES_RST   = 16'h0000;

  typedef enum logic [1:0] {
    SEL_NONE     = 2'h0,
    SEL_STANDARD = 2'h1,
    SEL_PULSE    = 2'h2
  } cte_sel_t;

  typedef enum logic [1:0] {
    RUN_SW     = 2'h0,
    RUN_STREAM = 2'h1,
    RUN_ASYNC  = 2'h2,
    RUN_PULSE  = 2'h3
  } cte_run_t;

  typedef enum logic [4:0] {
    ST_IDLE    = 5'h01,
    ST_ARMED   = 5'h02,
    ST_EXPOSE  = 5'h04,
    ST_READOUT = 5'h08,
    ST_WAIT    = 5'h10
  } cte_state_t;
endpackage
`default_nettype wire

// ==== hdl/cte_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module cte_sync
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic din,
  output logic      dout
);
  logic meta_reg;
  logic sync_reg;

  // Two flops; only the second one is looked at
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= din;
      sync_reg <= meta_reg;
    end
  end

  assign dout = sync_reg;
endmodule
`default_nettype wire

// ==== hdl/cte_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module cte_timer
#(
  parameter int W = 32
)
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         load,
  input  wire logic [W-1:0] val,
  output logic              zero
);
  logic [W-1:0] cnt_reg;

  // Down counter that parks at zero
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cnt_reg <= '0;
    else if (load)
      cnt_reg <= val;
    else if (cnt_reg != '0)
      cnt_reg <= cnt_reg - 1'b1;
  end

  assign zero = (cnt_reg == '0);
endmodule
`default_nettype wire

// ==== hdl/cte_top.sv ====
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module cte_top
#(
  parameter int TW = 32,
  parameter int FW = 16
)
(
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [cte_pkg::APB_AW-1:0] paddr,
  input  wire logic [cte_pkg::APB_DW-1:0] pwdata,
  output logic      [cte_pkg::APB_DW-1:0] prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      trigger_in,
  output logic                           exposure_active,
  output logic                           readout_active
);
  import cte_pkg::*;

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  logic [2:0]        ctrl_reg;
  logic [TW-1:0]     exp_reg;
  logic [TW-1:0]     int_reg;
  logic [TW-1:0]     rdo_reg;
  logic [FW-1:0]     frames_reg;
  logic [APB_DW-1:0] prdata_reg;
  logic [FW-1:0]     cnt_reg;
  logic [FW-1:0]     target_reg;
  cte_run_t          run_reg;
  cte_state_t        state_reg;
  cte_state_t        state_next;
  logic              exposure_reg;
  logic              readout_reg;

  wire wr_en    = psel & penable & pwrite;
  wire rd_setup = psel & ~penable & ~pwrite;
  wire hit_ctrl = (paddr == ADDR_CTRL);
  wire hit_cmd  = (paddr == ADDR_CMD);
  wire hit_exp  = (paddr == ADDR_EXPOSURE);
  wire hit_int  = (paddr == ADDR_INTERVAL);
  wire hit_rdo  = (paddr == ADDR_READOUT);
  wire hit_frm  = (paddr == ADDR_FRAMES);
  wire hit_stat = (paddr == ADDR_STATUS);
  wire hit_any  = hit_ctrl | hit_cmd | hit_exp | hit_int | hit_rdo | hit_frm | hit_stat;

  wire start_cmd = wr_en & hit_cmd & pwdata[CMD_START_BIT];
  wire halt_cmd  = wr_en & hit_cmd & pwdata[CMD_HALT_BIT];

  // Status word shows the engine's own state and progress
  wire [APB_DW-1:0] stat_word = {cnt_reg, 6'h00, readout_reg, exposure_reg, 3'h0, state_reg};

  // Read mux; command register reads zero
  wire [APB_DW-1:0] rd_mux =
    hit_ctrl ? {29'h0000_0000, ctrl_reg} :
    hit_exp  ? exp_reg :
    hit_int  ? int_reg :
    hit_rdo  ? rdo_reg :
    hit_frm  ? {{(APB_DW-FW){1'b0}}, frames_reg} :
    hit_stat ? stat_word :
    32'h0000_0000;

  // Zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit_any;
  assign prdata  = prdata_reg;

  // Read data is captured in the setup cycle so it comes from a flop
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      prdata_reg <= 32'h0000_0000;
    else if (rd_setup)
      prdata_reg <= rd_mux;
  end

  // Configuration writes
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_reg   <= CTRL_RST;
      exp_reg    <= EXPOSURE_RST[TW-1:0];
      int_reg    <= INTERVAL_RST[TW-1:0];
      rdo_reg    <= READOUT_RST[TW-1:0];
      frames_reg <= FRAMES_RST[FW-1:0];
    end
    else if (wr_en)
    begin
      if (hit_ctrl)
        ctrl_reg <= pwdata[2:0];
      if (hit_exp)
        exp_reg <= pwdata[TW-1:0];
      if (hit_int)
        int_reg <= pwdata[TW-1:0];
      if (hit_rdo)
        rdo_reg <= pwdata[TW-1:0];
      if (hit_frm)
        frames_reg <= pwdata[FW-1:0];
    end
  end

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  // Trigger select and frame count feed the decode, so readout settings cannot change it
  wire [1:0] sel_f      = ctrl_reg[CTRL_SEL_LSB +: 2];
  wire       pol_high   = ctrl_reg[CTRL_POL_BIT];
  wire       sel_std    = (sel_f == SEL_STANDARD);
  wire       sel_pulse  = (sel_f == SEL_PULSE);
  wire       one_frame  = (frames_reg == FW'(1));
  // Unused code 3 behaves as no hardware trigger
  cte_run_t  start_mode;
  assign start_mode = sel_pulse ? RUN_PULSE :
                      (sel_std & one_frame) ? RUN_ASYNC :
                      sel_std ? RUN_STREAM :
                      RUN_SW;

  // ----------------------------------------
  // Trigger conditioning
  // ----------------------------------------
  logic trig_s;
  logic trig_d_reg;

  cte_sync u_sync
  (
    .clk  (clk),
    .rst  (rst),
    .din  (trigger_in),
    .dout (trig_s)
  );

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      trig_d_reg <= 1'b0;
    else
      trig_d_reg <= trig_s;
  end

  // Polarity turns the line into an asserted level
  wire act         = pol_high ? trig_s : ~trig_s;
  wire act_d       = pol_high ? trig_d_reg : ~trig_d_reg;
  wire assert_edge = act & ~act_d;
  wire release_edge = ~act & act_d;

  // ----------------------------------------
  // Phase and interval timers
  // ----------------------------------------
  logic ph_zero;
  logic int_zero;

  // Zero length counts as one cycle
  wire [TW-1:0] exp_m1 = (exp_reg == '0) ? '0 : exp_reg - 1'b1;
  wire [TW-1:0] rdo_m1 = (rdo_reg == '0) ? '0 : rdo_reg - 1'b1;
  wire [TW-1:0] int_m1 = (int_reg == '0) ? '0 : int_reg - 1'b1;

  wire enter_exp = (state_next == ST_EXPOSE) & (state_reg != ST_EXPOSE);
  wire enter_rdo = (state_next == ST_READOUT) & (state_reg != ST_READOUT);
  wire ph_load   = enter_exp | enter_rdo;
  wire [TW-1:0] ph_val = enter_rdo ? rdo_m1 : exp_m1;

  cte_timer #(.W(TW)) u_phase
  (
    .clk  (clk),
    .rst  (rst),
    .load (ph_load),
    .val  (ph_val),
    .zero (ph_zero)
  );

  // Frame period runs from one exposure start to the next
  cte_timer #(.W(TW)) u_interval
  (
    .clk  (clk),
    .rst  (rst),
    .load (enter_exp),
    .val  (int_m1),
    .zero (int_zero)
  );

  // ----------------------------------------
  // Acquisition sequencer
  // ----------------------------------------
  wire last_frame = (target_reg != '0) & (cnt_reg + 1'b1 == target_reg);
  wire free_run   = (run_reg == RUN_SW) | (run_reg == RUN_STREAM);
  wire exp_done   = (run_reg == RUN_PULSE) ? release_edge : ph_zero;

  // Next state; halt overrides everything
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
        if (start_cmd)
          state_next = (start_mode == RUN_SW) ? ST_EXPOSE : ST_ARMED;
      ST_ARMED:
        if (assert_edge)
          state_next = ST_EXPOSE;
      ST_EXPOSE:
        if (exp_done)
          state_next = ST_READOUT;
      ST_READOUT:
        // Trigger edges are not looked at here
        if (ph_zero)
        begin
          if (last_frame & free_run)
            state_next = ST_IDLE;
          else if (free_run)
            state_next = ST_WAIT;
          else
            state_next = ST_ARMED;
        end
      ST_WAIT:
        // Only the interval restarts a frame, never the trigger
        if (int_zero)
          state_next = ST_EXPOSE;
      default:
        state_next = ST_IDLE;
    endcase
    if (halt_cmd)
      state_next = ST_IDLE;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  // Mode and frame target are frozen at start so later writes cannot upset a run
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      run_reg    <= RUN_SW;
      target_reg <= '0;
    end
    else if (start_cmd & (state_reg == ST_IDLE))
    begin
      run_reg    <= start_mode;
      target_reg <= frames_reg;
    end
  end

  // Frames read out since start
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cnt_reg <= '0;
    else if (start_cmd & (state_reg == ST_IDLE))
      cnt_reg <= '0;
    else if ((state_reg == ST_READOUT) & ph_zero)
      cnt_reg <= cnt_reg + 1'b1;
  end

  // Indicator outputs registered from the next state
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      exposure_reg <= 1'b0;
      readout_reg  <= 1'b0;
    end
    else
    begin
      exposure_reg <= (state_next == ST_EXPOSE);
      readout_reg  <= (state_next == ST_READOUT);
    end
  end

  assign exposure_active = exposure_reg;
  assign readout_active  = readout_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [TW-1:0] exp_cyc_reg;
  logic [TW-1:0] exp_need_reg;

  // Helper: cycles spent in exposure and the length asked for
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      exp_cyc_reg  <= '0;
      exp_need_reg <= '0;
    end
    else if (enter_exp)
    begin
      exp_cyc_reg  <= '0;
      exp_need_reg <= exp_m1 + 1'b1;
    end
    else if (state_reg == ST_EXPOSE)
      exp_cyc_reg <= exp_cyc_reg + 1'b1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_EXP_LEN: assert property (
    (state_reg == ST_EXPOSE) && (run_reg != RUN_PULSE) && (state_next == ST_READOUT)
    |-> (exp_cyc_reg + 1'b1 == exp_need_reg))
    else $error("timed exposure length wrong");

  AST_STREAM_REPEAT: assert property (
    (state_reg == ST_READOUT) && (run_reg == RUN_STREAM) && ph_zero && !last_frame && !halt_cmd
    |=> (state_reg == ST_WAIT))
    else $error("streaming did not go on to next frame");

  AST_STREAM_NO_REARM: assert property (
    (run_reg == RUN_STREAM) && (state_reg != ST_IDLE) && (state_reg != ST_ARMED)
    |=> (state_reg != ST_ARMED))
    else $error("streaming rearmed on trigger");

  AST_RDO_IGNORE: assert property (
    (state_reg == ST_READOUT) && assert_edge && !ph_zero && !halt_cmd
    |=> (state_reg == ST_READOUT) && !exposure_active)
    else $error("trigger acted during readout");

  AST_ASYNC_WAIT: assert property (
    (run_reg == RUN_ASYNC) && (state_reg == ST_ARMED) && !assert_edge && !halt_cmd
    |=> (state_reg == ST_ARMED) ##1 !exposure_active || (state_reg == ST_EXPOSE))
    else $error("async started without trigger edge");

  AST_PULSE_END: assert property (
    (run_reg == RUN_PULSE) && (state_reg == ST_EXPOSE) && release_edge && !halt_cmd
    |=> (state_reg == ST_READOUT) ##1 !exposure_active)
    else $error("pulse exposure did not end on release");

  AST_PULSE_HOLD: assert property (
    (run_reg == RUN_PULSE) && (state_reg == ST_EXPOSE) && act && !halt_cmd
    |=> exposure_active)
    else $error("pulse exposure ended while asserted");

  AST_EXP_OUT: assert property (
    exposure_active == (state_reg == ST_EXPOSE))
    else $error("exposure output out of step");

  AST_SW_NO_TRIG: assert property (
    (run_reg == RUN_SW) |-> (state_reg != ST_ARMED))
    else $error("software mode waited on trigger");

  AST_MODE_ASYNC: assert property (
    start_cmd && (state_reg == ST_IDLE) && sel_std && one_frame && !halt_cmd
    |=> (run_reg == RUN_ASYNC) && (state_reg == ST_ARMED))
    else $error("single frame did not select async");
endmodule
`default_nettype wire

// ==== tb/cte_trig_src.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// External trigger source
// ----------------------------------------
module cte_trig_src
(
  input  wire logic clk,
  output logic      trig
);
  logic idle_lvl;

  // Line parked low until a polarity is chosen
  initial
  begin
    idle_lvl = 1'b0;
    trig     = 1'b0;
  end

  // Park at the inactive level so no stray edge is seen
  task automatic park(input logic active_high);
    @(posedge clk);
    idle_lvl <= ~active_high;
    trig     <= ~active_high;
  endtask

  // One active pulse of width clocks, then back to idle
  task automatic pulse(input int width);
    @(posedge clk);
    trig <= ~idle_lvl;
    repeat (width) @(posedge clk);
    trig <= idle_lvl;
  endtask
endmodule
`default_nettype wire

// ==== tb/cte_top_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Bench top
// ----------------------------------------
module cte_top_bench;
  import cte_pkg::*;
  logic              clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [APB_AW-1:0] paddr;
  logic [APB_DW-1:0] pwdata, prdata, rd;
  logic              trigger_in, exposure_active, readout_active;
  int                n_mismatch, checks, seed, cyc, cur_len, rd_len, e, w1, w2;
  int                len_q[$], start_q[$], exp_q[$];
  logic [31:0]       rst_val[8];

  // Clock of 50 ns period
  initial clk = 1'b0;
  always #25 clk = ~clk;

  cte_top i_cte_top (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trigger_in(trigger_in),
    .exposure_active(exposure_active), .readout_active(readout_active));
  cte_trig_src i_cte_trig_src (.clk(clk), .trig(trigger_in));

  // Comparison tasks, one per kind of result
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_exp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t exposure got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Verdict and end of run
  task automatic stop_test;
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Exposure monitor: records start cycle and length of every exposure
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (rst === 1'b0)
    begin
      if (exposure_active === 1'b1 && readout_active === 1'b1)
        chk_exp(32'h0000_0001, 32'h0000_0000);
      if (exposure_active === 1'b1)
      begin
        if (cur_len == 0)
          start_q.push_back(cyc);
        cur_len++;
      end
      else if (cur_len != 0)
      begin
        len_q.push_back(cur_len);
        cur_len = 0;
      end
      // Every readout must last the programmed eight cycles
      if (readout_active === 1'b1)
        rd_len++;
      else if (rd_len != 0)
      begin
        chk_exp(rd_len, 32'h0000_0008);
        rd_len = 0;
      end
    end
  end

  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] d);
    int t;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    t = 0;
    do
    begin
      @(posedge clk);
      t++;
    end
    while (pready !== 1'b1 && t < 50);
    if (t >= 50)
      chk_reg(32'h0000_0000, 32'h0000_0001);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Junk on a deselected bus must not reach any register
    paddr   <= 8'($random(seed));
    pwdata  <= $random(seed);
  endtask

  // Bounded wait for a design output level
  task automatic wait_v(ref logic s, input logic v);
    int t;
    t = 0;
    while (s !== v && t < 4000)
    begin
      @(posedge clk);
      t++;
    end
    if (t >= 4000)
      chk_exp(32'h0000_0000, 32'h0000_0001);
  endtask

  // Program a run with readout 8 and interval 30 cycles, then start it
  task automatic setup(input logic [1:0] sel, input logic pol, input logic [31:0] frames);
    e = 3 + ({$random(seed)} % 8);
    apb(1'b1, ADDR_CTRL, {29'h0000_0000, pol, sel});
    apb(1'b1, ADDR_EXPOSURE, e);
    apb(1'b1, ADDR_READOUT, 32'h0000_0008);
    apb(1'b1, ADDR_INTERVAL, 32'h0000_001E);
    apb(1'b1, ADDR_FRAMES, frames);
    i_cte_trig_src.park(pol);
    len_q.delete();
    start_q.delete();
    apb(1'b1, ADDR_CMD, 32'h0000_0001);
  endtask

  // Halt, then compare recorded exposures with the model
  task automatic done(input string name);
    apb(1'b1, ADDR_CMD, 32'h0000_0002);
    repeat (4) @(posedge clk);
    chk_exp(len_q.size(), exp_q.size());
    foreach (exp_q[i])
      if (i < len_q.size())
        chk_exp(len_q[i], exp_q[i]);
    $display("test %s done", name);
  endtask

  // Watchdog well beyond the expected several hundred cycles
  initial
  begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    stop_test;
  end

  // Main sequence
  initial
  begin
    seed       = 72;
    rst        = 1'b1;
    psel       = 1'b0;
    penable    = 1'b0;
    // Idle bus lines carry junk; the slave must ignore them while deselected
    pwrite     = 1'($random(seed));
    paddr      = 8'($random(seed));
    pwdata     = $random(seed);
    n_mismatch = 0;
    checks     = 0;
    cyc        = 0;
    cur_len    = 0;
    rd_len     = 0;
    rst_val = '{32'(CTRL_RST), 32'h0000_0000, EXPOSURE_RST, INTERVAL_RST,
                READOUT_RST, 32'(FRAMES_RST), 32'(ST_IDLE), 32'h0000_0000};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    // Reset values, write-only command, unmapped word refused
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b0, 8'(i * 4), $random(seed));
      chk_reg(rd, rst_val[i]);
      chk_reg(err, i == 7);
    end
    $display("test regs done");
    // Single-frame triggered: one exposure per fresh edge
    setup(2'h1, 1'b1, 32'h0000_0001);
    exp_q = '{e, e};
    i_cte_trig_src.pulse(2);
    wait_v(readout_active, 1'b1);
    i_cte_trig_src.pulse(2);
    wait_v(readout_active, 1'b0);
    repeat (10) @(posedge clk);
    chk_exp(len_q.size(), 1);
    i_cte_trig_src.pulse(2);
    wait_v(readout_active, 1'b1);
    wait_v(readout_active, 1'b0);
    done("async");
    // Streaming, active low: later edges ignored, frames at interval
    setup(2'h1, 1'b0, 32'h0000_0003);
    exp_q = '{e, e, e};
    repeat (6) i_cte_trig_src.pulse(7);
    repeat (90) @(posedge clk);
    i_cte_trig_src.pulse(2);
    repeat (40) @(posedge clk);
    // Run stopped by itself after three frames
    apb(1'b0, ADDR_STATUS, $random(seed));
    chk_reg(rd, {16'h0003, 11'h000, ST_IDLE});
    for (int i = 1; i < start_q.size(); i++)
      chk_exp(start_q[i] - start_q[i-1], 30);
    done("stream");
    // Pulse width exposure, active low: width sets length
    setup(2'h2, 1'b0, 32'h0000_0000);
    w1 = 4 + ({$random(seed)} % 8);
    w2 = 4 + ({$random(seed)} % 8);
    exp_q = '{w1, w2};
    i_cte_trig_src.pulse(w1);
    wait_v(readout_active, 1'b1);
    i_cte_trig_src.pulse(2);
    wait_v(readout_active, 1'b0);
    i_cte_trig_src.pulse(w2);
    wait_v(readout_active, 1'b1);
    wait_v(readout_active, 1'b0);
    done("pulse");
    // Software capture of two frames; unused select code 3 also means none
    w1 = {$random(seed)} % 2;
    setup(w1 ? 2'h3 : 2'h0, 1'b1, 32'h0000_0002);
    exp_q = '{e, e};
    repeat (5) i_cte_trig_src.pulse(3);
    repeat (80) @(posedge clk);
    done("software");
    stop_test;
  end
endmodule
`default_nettype wire
